// ===== hdl/sdp_dev.sv
// sdram device end: samples pins, decodes commands, runs bursts
// assumes controller shares clk_i and keeps its own pin rules
// Function
// - all inputs taken on rising clock edge
// - each edge in run state advances output pipe, and burst column while a burst runs
// - clock gate low: power-down, self refresh, suspend
// - gate sampled synchronously, in low power as well
// - low power ignores all inputs but the gate
// - controller may hold gate permanently high
// - chip select low enables decoder, high ignores
// - running bursts and masks continue with select high
// - command from strobes and select on one edge
// - write mask high blocks that byte
// - read mask high floats lane two clocks later
// - mask bit n governs data byte n
// - bank inputs choose target bank
// - activate takes row from address
// - read/write: low bits column, bit ten autoprecharge
// - precharge: bit ten high means all banks
// - mode load takes opcode from address
// - one shared 32-bit two-way data bus
// - access is activate then read or write
// - burst lengths 1,2,4,8, full page, terminate
// - autoprecharge closes row at burst end
`timescale 1ns/100ps
`include "sdp_cfg.svh"
module sdp_dev
	import sdp_pkg::*;
#(
	parameter int ROW_W = `SDP_ROW_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	sdp_if.dev pins,
	output logic [`SDP_ADDR_W-1:0] mode_o,
	output sdp_pwr_e pwr_o,
	output logic [`SDP_BANKS-1:0] open_o
);
	localparam int CW = `SDP_COL_W;
	localparam int AW = 2 + ROW_W + CW;
	localparam int L = `SDP_LANES;
	localparam int DW = `SDP_DQ_W;
	localparam int NB = `SDP_BANKS;
	localparam int LAT = `SDP_DQM_LAT;

	sdp_pwr_e pwr_q, pwr_d;
	logic [`SDP_ADDR_W-1:0] mr_q, mr_d;
	logic [NB-1:0] open_q, open_d;
	logic [ROW_W-1:0] row_q [NB];
	logic [ROW_W-1:0] row_d [NB];
	logic bact_q, bact_d;
	logic bwr_q, bwr_d;
	logic bap_q, bap_d;
	logic [1:0] bba_q, bba_d;
	logic [CW-1:0] bcol_q, bcol_d;
	logic [CW:0] bleft_q, bleft_d;
	logic [L-1:0] dqm_q [LAT];
	logic [L-1:0] dqm_d [LAT];
	logic [2:0] v_q, v_d;
	logic [DW-1:0] p2_q, p2_d, p3_q, p3_d;

	logic en;
	logic cmd_ok;
	sdp_cmd_e cmd;
	logic [CW:0] blen;
	logic [CW-1:0] bmask;
	logic full;
	logic start;
	logic beat;
	logic [CW-1:0] cur_col;
	logic [1:0] cur_ba;
	logic cur_wr;
	logic [CW:0] left;
	logic [L-1:0] mem_we;
	logic mem_re;
	logic [DW-1:0] rdata;
	logic [DW-1:0] out_d;
	logic out_v;
	logic [2:0] cl;

	// ****************************************
	// array
	// ****************************************
	sdp_mem #(
		.AW(AW),
		.L(L)
	) u_mem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.we_i(mem_we),
		.re_i(mem_re),
		.addr_i({cur_ba, row_q[cur_ba], cur_col}),
		.wdata_i(pins.dq),
		.rdata_o(rdata)
	);

	// ****************************************
	// decode and burst control
	// ****************************************
	always_comb begin
		// internal clock only in run state
		en = (pwr_q == pwr_run);
		cmd = sdp_cmd_e'({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
		cmd_ok = en & ~pins.cs_n;
		full = (mr_q[`SDP_MR_BL_LSB +: 3] == `SDP_BL_FULL);
		case (mr_q[`SDP_MR_BL_LSB +: 3])
			3'h1: blen = 9'h002;
			3'h2: blen = 9'h004;
			3'h3: blen = 9'h008;
			`SDP_BL_FULL: blen = 9'h100;
			default: blen = 9'h001;
		endcase
		bmask = CW'(blen - 9'h001);
		cl = mr_q[`SDP_MR_CL_LSB +: 3];
		// bank from bank inputs, only open rows
		start = cmd_ok & ((cmd == cmd_read) | (cmd == cmd_write)) & open_q[pins.ba];
		// burst runs on regardless of select
		beat = en & (start | (bact_q & ~(cmd_ok & (cmd == cmd_burst_stop))));
		// starting column from low address bits
		cur_col = start ? pins.addr[CW-1:0] : bcol_q;
		cur_ba = start ? pins.ba : bba_q;
		cur_wr = start ? (cmd == cmd_write) : bwr_q;
		left = start ? blen : bleft_q;
		mem_we = {L{beat & cur_wr}} & ~pins.dqm;
		mem_re = beat & ~cur_wr;

		mr_d = mr_q;
		open_d = open_q;
		row_d = row_q;
		bact_d = bact_q;
		bwr_d = bwr_q;
		bap_d = bap_q;
		bba_d = bba_q;
		bcol_d = bcol_q;
		bleft_d = bleft_q;
		if (start) begin
			bwr_d = cur_wr;
			bba_d = cur_ba;
			bap_d = pins.addr[`SDP_AP_BIT];
		end
		if (cmd_ok) begin
			case (cmd)
				cmd_activate: begin
					open_d[pins.ba] = 1'b1;
					row_d[pins.ba] = pins.addr[ROW_W-1:0];
				end
				cmd_precharge: begin
					if (pins.addr[`SDP_AP_BIT])
						open_d = '0;
					else
						open_d[pins.ba] = 1'b0;
				end
				cmd_mode_load: mr_d = pins.addr;
				cmd_burst_stop: bact_d = 1'b0;
				default: ;
			endcase
		end
		if (beat) begin
			bcol_d = (cur_col & ~bmask) | ((cur_col + 8'h01) & bmask);
			bleft_d = full ? left : left - 9'h001;
			bact_d = full | (left != 9'h001);
			if (!full && left == 9'h001 && (start ? pins.addr[`SDP_AP_BIT] : bap_q))
				open_d[cur_ba] = 1'b0;
		end
	end

	// ****************************************
	// power states
	// ****************************************
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			pwr_run: begin
				// gate low picks the low power state
				if (!pins.cke) begin
					if (cmd_ok && cmd == cmd_refresh)
						pwr_d = pwr_sref;
					else if (bact_d)
						pwr_d = pwr_susp;
					else
						pwr_d = pwr_pdn;
				end
			end
			// wake on gate alone, other pins unused
			pwr_pdn, pwr_sref, pwr_susp: begin
				if (pins.cke)
					pwr_d = pwr_run;
			end
			default: pwr_d = pwr_run;
		endcase
	end

	// ****************************************
	// read pipe and output mask
	// ****************************************
	always_comb begin
		v_d = v_q;
		p2_d = p2_q;
		p3_d = p3_q;
		dqm_d = dqm_q;
		if (en) begin
			// pipe moves on every live edge
			v_d = {v_q[1:0], mem_re};
			p2_d = rdata;
			p3_d = p2_q;
			dqm_d[0] = pins.dqm;
			for (int i = 1; i < LAT; i++)
				dqm_d[i] = dqm_q[i-1];
		end
		case (cl)
			3'h1: begin
				out_d = rdata;
				out_v = v_q[0];
			end
			3'h2: begin
				out_d = p2_q;
				out_v = v_q[1];
			end
			default: begin
				out_d = p3_q;
				out_v = v_q[2];
			end
		endcase
	end

	// device drives bus only for read data
	for (genvar g = 0; g < L; g++) begin : g_oe
		assign pins.dev_dq_oe[g] = out_v & ~dqm_q[LAT-1][g];
	end
	assign pins.dev_dq_o = out_d;
	assign mode_o = mr_q;
	assign pwr_o = pwr_q;
	assign open_o = open_q;

	// ****************************************
	// registers
	// ****************************************
	// every input sampled on rising edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwr_q <= pwr_run;
			mr_q <= `SDP_MR_RST;
			open_q <= '0;
			for (int i = 0; i < NB; i++)
				row_q[i] <= '0;
			bact_q <= 1'b0;
			bwr_q <= 1'b0;
			bap_q <= 1'b0;
			bba_q <= 2'h0;
			bcol_q <= '0;
			bleft_q <= '0;
			for (int i = 0; i < LAT; i++)
				dqm_q[i] <= 4'hf;
			v_q <= 3'h0;
			p2_q <= '0;
			p3_q <= '0;
		end else begin
			pwr_q <= pwr_d;
			mr_q <= mr_d;
			open_q <= open_d;
			row_q <= row_d;
			bact_q <= bact_d;
			bwr_q <= bwr_d;
			bap_q <= bap_d;
			bba_q <= bba_d;
			bcol_q <= bcol_d;
			bleft_q <= bleft_d;
			dqm_q <= dqm_d;
			v_q <= v_d;
			p2_q <= p2_d;
			p3_q <= p3_d;
		end
	end
endmodule

// ===== hdl/sdp_cfg.svh
// constants of the sdram pin interface: offsets, fields, resets, counts
// assumes inclusion by bare name from package and modules
`ifndef SDP_CFG_SVH
`define SDP_CFG_SVH
// ****************************************
// pins and array
// ****************************************
`define SDP_LANES 4
`define SDP_LANE_W 8
`define SDP_DQ_W 32
`define SDP_BANKS 4
`define SDP_ROW_W 12
`define SDP_COL_W 8
`define SDP_ADDR_W 12
`define SDP_AP_BIT 10
`define SDP_DQM_LAT 2
// ****************************************
// mode register
// ****************************************
`define SDP_MR_RST 12'h030
`define SDP_MR_BL_LSB 0
`define SDP_MR_CL_LSB 4
`define SDP_BL_FULL 3'h7
// ****************************************
// command codes {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define SDP_CMD_MODE 4'h0
`define SDP_CMD_REF 4'h1
`define SDP_CMD_PRE 4'h2
`define SDP_CMD_ACT 4'h3
`define SDP_CMD_WR 4'h4
`define SDP_CMD_RD 4'h5
`define SDP_CMD_BST 4'h6
`define SDP_CMD_NOP 4'h7
// ****************************************
// controller registers
// ****************************************
`define SDP_OFS_CMD 8'h00
`define SDP_OFS_WDAT 8'h04
`define SDP_OFS_CFG 8'h08
`define SDP_OFS_RDAT 8'h0c
`define SDP_OFS_STAT 8'h10
`define SDP_CMDR_BA_LSB 4
`define SDP_CMDR_AD_LSB 6
`define SDP_CFG_RST 8'h03
`define SDP_CFG_LAT_LSB 1
`define SDP_CFG_DQM_LSB 4
`define SDP_STAT_BUSY 0
`define SDP_STAT_RVLD 1
`define SDP_GAP_CYC 3'h2
`endif

// ===== hdl/sdp_pkg.sv
// types shared by both ends of the sdram pin interface
// assumes sdp_cfg.svh on the include path
package sdp_pkg;
`include "sdp_cfg.svh"
	typedef enum logic [3:0] {
		cmd_mode_load = `SDP_CMD_MODE,
		cmd_refresh = `SDP_CMD_REF,
		cmd_precharge = `SDP_CMD_PRE,
		cmd_activate = `SDP_CMD_ACT,
		cmd_write = `SDP_CMD_WR,
		cmd_read = `SDP_CMD_RD,
		cmd_burst_stop = `SDP_CMD_BST,
		cmd_nop = `SDP_CMD_NOP
	} sdp_cmd_e;
	typedef enum logic [3:0] {
		pwr_run = 4'b0001,
		pwr_pdn = 4'b0010,
		pwr_sref = 4'b0100,
		pwr_susp = 4'b1000
	} sdp_pwr_e;
	typedef enum logic [3:0] {
		cst_idle = 4'b0001,
		cst_gap = 4'b0010,
		cst_issue = 4'b0100,
		cst_wait = 4'b1000
	} sdp_cst_e;
endpackage

// ===== hdl/sdp_if.sv
// pin bundle between memory controller and sdram device
// assumes both ends share one clock; data wire resolved here per lane
`timescale 1ns/100ps
`include "sdp_cfg.svh"
interface sdp_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic [`SDP_ADDR_W-1:0] addr;
	logic [`SDP_LANES-1:0] dqm;
	logic [`SDP_DQ_W-1:0] ctl_dq_o;
	logic ctl_dq_oe;
	logic [`SDP_DQ_W-1:0] dev_dq_o;
	logic [`SDP_LANES-1:0] dev_dq_oe;
	logic [`SDP_DQ_W-1:0] dq;
	// ****************************************
	// bus level per byte lane
	// ****************************************
	for (genvar g = 0; g < `SDP_LANES; g++) begin : g_ln
		assign dq[g*`SDP_LANE_W +: `SDP_LANE_W] = dev_dq_oe[g] ?
			dev_dq_o[g*`SDP_LANE_W +: `SDP_LANE_W] :
			(ctl_dq_oe ? ctl_dq_o[g*`SDP_LANE_W +: `SDP_LANE_W] : 8'h00);
	end
	modport dev (
		input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output dev_dq_o, dev_dq_oe
	);
	modport ctl (
		output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_o, ctl_dq_oe,
		input dq
	);
endinterface

// ===== hdl/sdp_mem.sv
// byte-lane storage array with registered read
// assumes one write or one read per clock from the device end
`timescale 1ns/100ps
`include "sdp_cfg.svh"
module sdp_mem #(
	parameter int AW = 2 + `SDP_ROW_W + `SDP_COL_W,
	parameter int L = `SDP_LANES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [L-1:0] we_i,
	input wire logic re_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [L*`SDP_LANE_W-1:0] wdata_i,
	output logic [L*`SDP_LANE_W-1:0] rdata_o
);
	// ****************************************
	// one array per byte lane
	// ****************************************
	for (genvar g = 0; g < L; g++) begin : g_lane
		logic [`SDP_LANE_W-1:0] ram [2**AW];
		logic [`SDP_LANE_W-1:0] rd_q;
		always_ff @(posedge clk_i) begin
			if (we_i[g])
				ram[addr_i] <= wdata_i[g*`SDP_LANE_W +: `SDP_LANE_W];
			if (rst_i)
				rd_q <= 8'h00;
			else if (re_i)
				rd_q <= ram[addr_i];
		end
		assign rdata_o[g*`SDP_LANE_W +: `SDP_LANE_W] = rd_q;
	end
endmodule

// ===== hdl/sdp_ctl.sv
// memory controller end: wishbone registers drive sdram pins
// assumes classic wishbone master on clk_i and device on the same clock
`timescale 1ns/100ps
`include "sdp_cfg.svh"
module sdp_ctl
	import sdp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	sdp_if.ctl pins
);
	sdp_cst_e st_q, st_d;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [17:0] cmd_q, cmd_d;
	logic [31:0] wdat_q, wdat_d;
	logic [7:0] cfg_q, cfg_d;
	logic [31:0] rdat_q, rdat_d;
	logic rvld_q, rvld_d;
	logic [2:0] cnt_q, cnt_d;
	logic [3:0] pcmd_q, pcmd_d;
	logic [1:0] pba_q, pba_d;
	logic [11:0] padr_q, padr_d;
	logic [3:0] pdqm_q, pdqm_d;
	logic poe_q, poe_d;
	logic [31:0] pdq_q, pdq_d;
	logic wr;
	logic go;
	logic cap;
	logic [31:0] nw;
	logic [17:0] c;
	logic [2:0] lat;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		for (int i = 0; i < 4; i++)
			r[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
		return r;
	endfunction

	// ****************************************
	// wishbone slave and sequencer
	// ****************************************
	always_comb begin
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
		case (wb_adr_i)
			`SDP_OFS_CMD: dat_d = {14'h0000, cmd_q};
			`SDP_OFS_WDAT: dat_d = wdat_q;
			`SDP_OFS_CFG: dat_d = {24'h00_0000, cfg_q};
			`SDP_OFS_RDAT: dat_d = rdat_q;
			`SDP_OFS_STAT: dat_d = {30'h0000_0000, rvld_q, st_q != cst_idle};
			default: dat_d = 32'h0000_0000;
		endcase
		go = wr & (wb_adr_i == `SDP_OFS_CMD) & (st_q == cst_idle);
		nw = merge({14'h0000, cmd_q}, wb_dat_i, wb_sel_i);
		cmd_d = go ? nw[17:0] : cmd_q;
		wdat_d = (wr && wb_adr_i == `SDP_OFS_WDAT) ? merge(wdat_q, wb_dat_i, wb_sel_i) : wdat_q;
		cfg_d = (wr && wb_adr_i == `SDP_OFS_CFG && wb_sel_i[0]) ? wb_dat_i[7:0] : cfg_q;
		c = (st_q == cst_idle) ? nw[17:0] : cmd_q;
		lat = (cfg_q[`SDP_CFG_LAT_LSB +: 3] == 3'h0) ? 3'h1 : cfg_q[`SDP_CFG_LAT_LSB +: 3];
		cap = 1'b0;
		st_d = st_q;
		cnt_d = cnt_q;
		rdat_d = rdat_q;
		pcmd_d = `SDP_CMD_NOP;
		pba_d = pba_q;
		padr_d = padr_q;
		pdqm_d = cfg_q[`SDP_CFG_DQM_LSB +: 4];
		poe_d = 1'b0;
		pdq_d = pdq_q;
		case (st_q)
			cst_idle: begin
				if (go) begin
					if (nw[3:0] == `SDP_CMD_WR) begin
						st_d = cst_gap;
						cnt_d = `SDP_GAP_CYC;
						pdqm_d = 4'hf;
					end else
						st_d = cst_issue;
				end
			end
			cst_gap: begin
				cnt_d = cnt_q - 3'h1;
				// mask up only until the write cycle
				if (cnt_q == 3'h1)
					st_d = cst_issue;
				else
					pdqm_d = 4'hf;
			end
			cst_issue: begin
				st_d = (cmd_q[3:0] == `SDP_CMD_RD) ? cst_wait : cst_idle;
				cnt_d = lat;
			end
			cst_wait: begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1) begin
					cap = 1'b1;
					rdat_d = pins.dq;
					st_d = cst_idle;
				end
			end
			default: st_d = cst_idle;
		endcase
		// command, bank and address on one edge
		if (st_d == cst_issue && st_q != cst_issue) begin
			pcmd_d = c[3:0];
			pba_d = c[`SDP_CMDR_BA_LSB +: 2];
			padr_d = c[`SDP_CMDR_AD_LSB +: 12];
			poe_d = (c[3:0] == `SDP_CMD_WR);
			pdq_d = wdat_q;
		end
		// sticky read flag, set beats clear
		rvld_d = cap | (rvld_q & ~(wr && wb_adr_i == `SDP_OFS_STAT && wb_sel_i[0] &&
			wb_dat_i[`SDP_STAT_RVLD]));
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	// gate held from a register, high after reset
	assign pins.cke = cfg_q[0];
	assign pins.cs_n = pcmd_q[3];
	assign pins.ras_n = pcmd_q[2];
	assign pins.cas_n = pcmd_q[1];
	assign pins.we_n = pcmd_q[0];
	assign pins.ba = pba_q;
	assign pins.addr = padr_q;
	assign pins.dqm = pdqm_q;
	assign pins.ctl_dq_o = pdq_q;
	assign pins.ctl_dq_oe = poe_q;

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= cst_idle;
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			cmd_q <= 18'h0_0007;
			wdat_q <= 32'h0000_0000;
			cfg_q <= `SDP_CFG_RST;
			rdat_q <= 32'h0000_0000;
			rvld_q <= 1'b0;
			cnt_q <= 3'h0;
			pcmd_q <= `SDP_CMD_NOP;
			pba_q <= 2'h0;
			padr_q <= 12'h000;
			pdqm_q <= 4'hf;
			poe_q <= 1'b0;
			pdq_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
			cmd_q <= cmd_d;
			wdat_q <= wdat_d;
			cfg_q <= cfg_d;
			rdat_q <= rdat_d;
			rvld_q <= rvld_d;
			cnt_q <= cnt_d;
			pcmd_q <= pcmd_d;
			pba_q <= pba_d;
			padr_q <= padr_d;
			pdqm_q <= pdqm_d;
			poe_q <= poe_d;
			pdq_q <= pdq_d;
		end
	end
endmodule

// ===== tb/sdp_chk_props.sv
// checker of the pin link between controller end and device end
// assumes instance beside the interface, one clock, sync high reset
`timescale 1ns/100ps
`include "sdp_cfg.svh"
module sdp_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [`SDP_LANES-1:0] dqm,
	input wire logic ctl_dq_oe,
	input wire logic [`SDP_LANES-1:0] dev_dq_oe
);
	// ****************************************
	// helpers
	// ****************************************
	logic [3:0] code;
	assign code = {cs_n, ras_n, cas_n, we_n};
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_run3;
		cke [*3];
	endsequence
	sequence s_low3;
		!cke [*3];
	endsequence
	sequence s_wr_cmd;
		code == `SDP_CMD_WR;
	endsequence
	// ****************************************
	// properties
	// ****************************************
	a_bus_no_fight:
		assert property (!(ctl_dq_oe && (dev_dq_oe != 4'h0))) else $error("both ends drive data");
	a_mask_float_lat:
		assert property (s_run3 |-> ($past(dqm, 2) & dev_dq_oe) == 4'h0)
		else $error("masked lane driven");
	a_lanes_together:
		assert property (s_run3 ##0 (dev_dq_oe != 4'h0) |-> (dev_dq_oe | $past(dqm, 2)) == 4'hf)
		else $error("unmasked lane idle");
	a_cmd_one_cycle:
		assert property (code != `SDP_CMD_NOP |=> code == `SDP_CMD_NOP)
		else $error("command held too long");
	a_wr_oe_pair:
		assert property (ctl_dq_oe == (code == `SDP_CMD_WR)) else $error("write drive mismatch");
	a_wr_mask_gap:
		assert property (s_wr_cmd |-> $past(code) == `SDP_CMD_NOP && $past(code, 2) == `SDP_CMD_NOP
			&& $past(dqm) == 4'hf && $past(dqm, 2) == 4'hf) else $error("write gap missing");
	a_reset_idle:
		assert property ($fell(rst_i) |-> cke && code == `SDP_CMD_NOP && dqm == 4'hf && !ctl_dq_oe)
		else $error("pins not idle after reset");
	a_gated_hold:
		assert property (s_low3 |-> $stable(dev_dq_oe)) else $error("output moved while gated");
endmodule

// ===== tb/tb.sv
// self-checking bench: wishbone master drives controller, device answers
// assumes 250 MHz clock and the design files compiled first
`timescale 1ns/100ps
`include "sdp_cfg.svh"
module tb;
	import sdp_pkg::*;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i, c;
	logic [3:0] wb_sel_i, open_o, m, e;
	logic [31:0] wb_dat_i, wb_dat_o, rd_q, seed, r, d0, d1, ex;
	logic [11:0] mode_o;
	logic [1:0] b, nb;
	sdp_pwr_e pwr_o;
	int miscompares, checks_done;
	sdp_if pins_if ();
	sdp_dev #(.ROW_W(2)) sdp_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .pins(pins_if),
		.mode_o(mode_o), .pwr_o(pwr_o), .open_o(open_o));
	sdp_ctl sdp_ctl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins(pins_if));
	sdp_chk sdp_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .cke(pins_if.cke), .cs_n(pins_if.cs_n),
		.ras_n(pins_if.ras_n), .cas_n(pins_if.cas_n), .we_n(pins_if.we_n), .dqm(pins_if.dqm),
		.ctl_dq_oe(pins_if.ctl_dq_oe), .dev_dq_oe(pins_if.dev_dq_oe));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] lanes(input logic [3:0] k);
		return {{8{k[3]}}, {8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic op(input logic [3:0] k, input logic [1:0] bk, input logic [11:0] a);
		wb(1'b1, `SDP_OFS_CMD, {14'h0000, a, bk, k});
		do wb(1'b0, `SDP_OFS_STAT, 32'h0000_0000);
		while (rd_q[`SDP_STAT_BUSY] !== 1'b0);
	endtask
	task automatic cfg(input logic [3:0] k, input logic ck);
		wb(1'b1, `SDP_OFS_CFG, {24'h00_0000, k, 3'h2, ck});
	endtask
	task automatic wrd(input logic [31:0] d, input logic [3:0] k);
		cfg(k, 1'b1);
		wb(1'b1, `SDP_OFS_WDAT, d);
		op(`SDP_CMD_WR, b, {4'h0, c});
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		op(`SDP_CMD_RD, b, a);
		check(rd_q & 32'h0000_0002, 32'h0000_0002);
		wb(1'b0, `SDP_OFS_RDAT, 32'h0000_0000);
		check(rd_q, exp);
		wb(1'b1, `SDP_OFS_STAT, 32'h0000_0002);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ****************************************
	// clock, watchdog, sequence
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#(4 * 20000);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		seed = 32'h0000_84cb;
		rst_i <= 1'b1;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= 8'h00;
		wb_sel_i <= 4'h0;
		wb_dat_i <= 32'h0000_0000;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(32'(mode_o), 32'h0000_0030);
		check(32'(pwr_o), 32'(pwr_run));
		wb(1'b0, `SDP_OFS_CFG, 32'h0000_0000);
		check(rd_q, 32'h0000_0003);
		wb(1'b0, 8'h20, 32'h0000_0000);
		check(rd_q, 32'h0000_0000);
		op(`SDP_CMD_MODE, 2'h0, 12'h020);
		check(32'(mode_o), 32'h0000_0020);
		op(4'hb, 2'h2, 12'h000);
		check(32'(open_o), 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			op(`SDP_CMD_ACT, 2'(i), r[11:0]);
		end
		check(32'(open_o), 32'h0000_000f);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			b = r[1:0];
			c = r[9:2];
			m = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : r[13:10];
			d0 = rnd();
			d1 = rnd();
			ex = (d0 & lanes(m)) | (d1 & ~lanes(m));
			wrd(d0, 4'h0);
			wrd(d1, m);
			cfg(4'h0, 1'b1);
			rdchk({4'h0, c}, ex);
			cfg(m, 1'b1);
			rdchk({4'h0, c}, ex & ~lanes(m));
		end
		rdchk({4'h4, c}, ex & ~lanes(m));
		e = 4'hf;
		e[b] = 1'b0;
		check(32'(open_o), 32'(e));
		nb = b ^ 2'h1;
		op(`SDP_CMD_PRE, nb, 12'h000);
		e[nb] = 1'b0;
		check(32'(open_o), 32'(e));
		op(4'ha, 2'h0, 12'h400);
		check(32'(open_o), 32'(e));
		cfg(4'h0, 1'b0);
		repeat (2) @(posedge clk_i);
		check(32'(pwr_o), 32'(pwr_pdn));
		op(`SDP_CMD_ACT, b, 12'h000);
		check(32'(open_o), 32'(e));
		cfg(4'h0, 1'b1);
		repeat (2) @(posedge clk_i);
		check(32'(pwr_o), 32'(pwr_run));
		op(`SDP_CMD_MODE, 2'h0, 12'h037);
		op(`SDP_CMD_RD, b ^ 2'h2, 12'h000);
		cfg(4'h0, 1'b0);
		repeat (2) @(posedge clk_i);
		check(32'(pwr_o), 32'(pwr_susp));
		cfg(4'h0, 1'b1);
		op(`SDP_CMD_BST, 2'h0, 12'h000);
		check(32'(pins_if.dev_dq_oe), 32'h0000_0000);
		op(`SDP_CMD_PRE, 2'h0, 12'h400);
		check(32'(open_o), 32'h0000_0000);
		tally_and_finish();
	end
endmodule
